// file: rtl/rx_video_path.sv
// Receive video path: port select, link decode, XOR decrypt, routing, output formatter
// Functional notes
// - Only the selected input port has its circuitry enabled
// - Ten-bit symbols decode to eight bits in video, four in islands
// - Stopped link clock and stopped video are flagged for software
// - Per-port source supply presence is readable in a status register
// - Exactly one display data channel is connected, chosen by software
// - A fresh cipher value XOR-masks audio and video on every valid symbol
// - Software sequence programs and starts decryption; receiver acts on it
// - Stored key material can never be read back
// - Decrypted words go to video, audio or auxiliary logic only
// - Each video stage has its own bypass bit
// - Embedded sync puts start and end codes into the data stream
// - With embedded sync, components clamp to 1 through 254
// - Half-width 4:4:4 modes carry data on both clock edges
// - A divided output clock is available for interlaced SD
// - Output supports 36/30/24/half-width 4:4:4 and 4:2:2 widths and syncs
// - Range scaling is chosen from the detected video format
// - 10 and 12-bit data scale by the same method as 8-bit
// - Chroma up-sampling 4:2:2 to 4:4:4 and down-sampling back
// - Internal processing keeps 14 bits
// - Link data accepted at any symbol rate up to the link maximum
// - Deep colour: link runs 5:4 or 3:2 faster, receiver divides back
// - After reset: RGB 4:4:4, 24-bit, full range, no processing
//
// Our own choices: the address map and the address-and-strobe port.
`include "rx_video_defs.svh"
`default_nettype none
module rx_video_path #(
  parameter int unsigned VID_STOP_CYC = `VID_STOP_NS / `CLK_PER_NS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Link symbols from the deserialisers and per-port supply sense
  input wire logic [29:0] SYM_P0,
  input wire logic [29:0] SYM_P1,
  input wire logic [1:0] SYM_VLD,
  input wire logic [1:0] PWR5V,
  // Port and data channel enables
  output logic [1:0] PORT_EN,
  output logic [1:0] DDC_EN,
  // Video, audio and auxiliary outputs
  output rx_video_pkg::vout_t VID_OUT,
  output rx_video_pkg::pkt_t AUD_OUT,
  output rx_video_pkg::pkt_t AUX_OUT
);
  // ----------------------------------------
  // Decode, scaling, clamping, width and cipher helpers
  // ----------------------------------------
  localparam logic [159:0] TERC4 = `TERC4_TAB;

  function automatic logic [7:0] dec8(input logic [9:0] s);
    logic [7:0] d;
    logic [7:0] o;
    d = s[9] ? ~s[7:0] : s[7:0];
    o[0] = d[0];
    for (int i = 1; i < 8; i++) begin
      o[i] = s[8] ? d[i] ^ d[i-1] : ~(d[i] ^ d[i-1]);
    end
    return o;
  endfunction : dec8

  function automatic logic [4:0] dec4(input logic [9:0] s);
    logic [4:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      if (s == TERC4[i*10 +: 10]) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction : dec4

  function automatic logic [2:0] ctl(input logic [9:0] s);
    logic [2:0] r;
    r = '0;
    if (s == `TOK_00) r = 3'h4;
    else if (s == `TOK_01) r = 3'h5;
    else if (s == `TOK_10) r = 3'h6;
    else if (s == `TOK_11) r = 3'h7;
    return r;
  endfunction : ctl

  function automatic logic [13:0] scale(input logic [13:0] x);
    logic [21:0] p;
    p = x * `RNG_MUL;
    return `RNG_OFS + p[21:8];
  endfunction : scale

  function automatic logic [13:0] clamp(input logic [13:0] x);
    logic [13:0] r;
    r = x;
    if (x < `CLMP_LO) r = `CLMP_LO;
    else if (x > `CLMP_HI) r = `CLMP_HI;
    return r;
  endfunction : clamp

  function automatic logic [11:0] trunc(input logic [13:0] x, input logic [1:0] w);
    logic [11:0] r;
    r = x[13:2];
    if (w == `W_30) r[1:0] = '0;
    else if (w == `W_24) r[3:0] = '0;
    return r;
  endfunction : trunc

  function automatic logic [23:0] step(input logic [23:0] l);
    return {l[22:0], l[23] ^ l[22] ^ l[21] ^ l[16]};
  endfunction : step

  // ----------------------------------------
  // State and symbol decode
  // ----------------------------------------
  rx_video_pkg::st_t st;
  rx_video_pkg::st_t n;
  logic vld;
  logic [29:0] sym;
  logic [23:0] m;
  logic [2:0] t0, t1, t2;
  logic [4:0] q0, q1, q2;
  logic [7:0] p0, p1, p2;
  logic [13:0] c0, c1, c2, ci;
  logic [11:0] r, y, b, w;
  logic [3:0] a;
  logic pix, de;

  // Only the selected port's symbols reach the core
  assign vld = st.ctrl[`B_PORT] ? SYM_VLD[1] : SYM_VLD[0];
  assign sym = st.ctrl[`B_PORT] ? SYM_P1 : SYM_P0;
  assign m = st.ctrl[`B_DEC] ? st.lfsr : '0;
  assign t0 = ctl(sym[9:0]);
  assign t1 = ctl(sym[19:10]);
  assign t2 = ctl(sym[29:20]);
  assign q0 = dec4(sym[9:0]);
  assign q1 = dec4(sym[19:10]);
  assign q2 = dec4(sym[29:20]);
  assign p0 = dec8(sym[9:0]) ^ m[7:0];
  assign p1 = dec8(sym[19:10]) ^ m[15:8];
  assign p2 = dec8(sym[29:20]) ^ m[23:16];

  always_comb begin
    n = st;
    c0 = '0;
    c1 = '0;
    c2 = '0;
    ci = '0;
    r = '0;
    y = '0;
    b = '0;
    w = '0;
    a = '0;
    pix = 1'b0;
    de = 1'b0;
    n.aud.vld = 1'b0;
    n.aux.vld = 1'b0;
    // Supply sense passes two flops before anything reads it
    n.pw1 = PWR5V;
    n.pw2 = st.pw1;
    n.ph = (st.ph == 2'h3) ? st.ph : st.ph + 2'h1;

    // ----------------------------------------
    // Clock and video activity
    // ----------------------------------------
    if (vld) begin
      n.idle = '0;
      n.clk_run = 1'b1;
      n.blank = 1'b0;
    end else if (st.idle != 8'(`CLK_STOP_CYC)) begin
      n.idle = st.idle + 8'h1;
    end else begin
      n.clk_run = 1'b0;
    end
    if (vld && st.mode == rx_video_pkg::LM_VID) begin
      n.vcnt = '0;
      n.vid_run = 1'b1;
    end else if (st.vcnt != 23'(VID_STOP_CYC)) begin
      n.vcnt = st.vcnt + 23'h1;
    end else begin
      n.vid_run = 1'b0;
    end

    // ----------------------------------------
    // Symbol period and routing
    // ----------------------------------------
    if (vld) begin
      if (st.ctrl[`B_DEC]) n.lfsr = step(st.lfsr);
      // Pixel enable recovers the pixel rate from the link rate
      if (st.vcfg[`F_DEEP] == `D_30) begin
        a = {1'b0, st.acc} + 4'h4;
        pix = a >= 4'h5;
        if (pix) a = a - 4'h5;
      end else if (st.vcfg[`F_DEEP] == `D_36) begin
        a = {1'b0, st.acc} + 4'h2;
        pix = a >= 4'h3;
        if (pix) a = a - 4'h3;
      end else begin
        pix = 1'b1;
      end
      n.acc = a[2:0];
      case (st.mode)
        rx_video_pkg::LM_CTRL: begin
          if (t0[2] && t1[2] && t2[2]) begin
            n.pre = {t2[1:0], t1[1:0]};
            n.hs = t0[0];
            n.vs = t0[1];
          end else if (st.pre == `PRE_VID) begin
            n.mode = rx_video_pkg::LM_VID;
          end else if (st.pre == `PRE_ISL) begin
            n.mode = rx_video_pkg::LM_ISL;
            n.hcnt = '0;
          end
        end
        rx_video_pkg::LM_VID, rx_video_pkg::LM_ISL: begin
          if (t0[2]) begin
            n.mode = rx_video_pkg::LM_CTRL;
            n.pre = '0;
            n.hs = t0[0];
            n.vs = t0[1];
          end
        end
        default: n.mode = rx_video_pkg::LM_CTRL;
      endcase
      // Island words: header bits decide audio or auxiliary
      if (st.mode == rx_video_pkg::LM_ISL && !t0[2]) begin
        w = {q2[3:0], q1[3:0], q0[3:0]} ^ m[11:0];
        n.hs = w[0];
        n.vs = w[1];
        if (st.hcnt != `HDR_LEN) begin
          n.hdr = {w[2], st.hdr[7:1]};
          n.hcnt = st.hcnt + 4'h1;
        end
        if (st.hcnt == `HDR_LEN && st.hdr == `PKT_AUD) begin
          n.aud = '{d: w, vld: 1'b1};
        end else begin
          n.aux = '{d: w, vld: 1'b1};
        end
      end
    end

    // ----------------------------------------
    // Pixel processing, 14-bit path
    // ----------------------------------------
    if (pix && st.vcfg[`B_DIV] && st.divt) begin
      n.divt = 1'b0;
    end else if (pix) begin
      n.divt = st.vcfg[`B_DIV];
      n.ph = '0;
      de = st.mode == rx_video_pkg::LM_VID && !t0[2];
      c0 = {p0, 6'h00};
      c1 = {p1, 6'h00};
      c2 = {p2, 6'h00};
      if (!de) begin
        c0 = '0;
        c1 = '0;
        c2 = '0;
      end
      n.ctog = de && (st.vcfg[`B_UP] || st.vcfg[`B_DN]) && !st.ctog;
      if (st.vcfg[`B_UP]) begin
        ci = c0;
        if (!st.ctog) begin
          n.cbh = ci;
          c2 = st.crh;
        end else begin
          n.crh = ci;
          c0 = st.cbh;
          c2 = ci;
        end
      end
      if (st.vcfg[`B_RNG] && st.ce_fmt) begin
        c0 = scale(c0);
        c1 = scale(c1);
        c2 = scale(c2);
      end
      if (st.vcfg[`B_DN] && st.ctog) c0 = c2;
      if (st.vcfg[`B_EMB]) begin
        c0 = clamp(c0);
        c1 = clamp(c1);
        c2 = clamp(c2);
      end
      // Format detection: only the VGA line length counts as IT timing
      if (de) n.pcnt = st.pcnt + 12'h1;
      if (st.de_q && !de) begin
        n.line_len = st.pcnt;
        n.ce_fmt = st.pcnt != `VGA_W;
        n.pcnt = '0;
      end
      // A code replaces the first word of each new DE state
      n.code = st.vcfg[`B_EMB] && (de != st.de_q);
      n.xy = {1'b1, 1'b0, st.vs, !de, st.vs ^ !de, !de, st.vs, st.vs ^ !de};
      n.de_q = de;
      n.pde = de;
      r = trunc(c2, st.vcfg[`F_WID]);
      y = trunc(c1, st.vcfg[`F_WID]);
      b = trunc(c0, st.vcfg[`F_WID]);
      if (st.vcfg[`B_MUX]) begin
        n.w0 = {24'h0, y};
        n.w1 = {24'h0, b};
      end else if (st.vcfg[`B_DDR]) begin
        n.w0 = {18'h0, r[5:0], y[5:0], b[5:0]};
        n.w1 = {18'h0, r[11:6], y[11:6], b[11:6]};
      end else begin
        n.w0 = {r, y, b};
        n.w1 = {r, y, b};
      end
    end

    // ----------------------------------------
    // Output bus
    // ----------------------------------------
    if (st.blank) begin
      n.vo = '0;
    end else begin
      if (st.code) begin
        case (st.ph)
          2'h0: n.vo.d = {3{`SAV_FF}};
          2'h3: n.vo.d = {3{st.xy, 4'h0}};
          default: n.vo.d = '0;
        endcase
      end else begin
        n.vo.d = st.ph[1] ? st.w1 : st.w0;
      end
      if (st.vcfg[`B_DIV]) n.vo.clk = st.divt;
      else if (st.vcfg[`B_MUX]) n.vo.clk = !st.ph[0];
      else n.vo.clk = !st.ph[1];
      n.vo.hs = st.hs && !st.vcfg[`B_EMB];
      n.vo.vs = st.vs && !st.vcfg[`B_EMB];
      n.vo.de = st.pde && !st.code;
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    n.rdata = '0;
    if (RD) begin
      if (ADDR == `A_CTRL) begin
        n.rdata = {29'h0, st.ctrl};
      end else if (ADDR == `A_VCFG) begin
        n.rdata = {21'h0, st.vcfg};
      end else if (ADDR == `A_STAT) begin
        n.rdata = {25'h0, st.mode, st.ce_fmt, st.vid_run, st.clk_run, st.pw2};
      end else if (ADDR == `A_LINE) begin
        n.rdata = {20'h0, st.line_len};
      end else begin
        n.rdata = '0;
      end
    end
    if (WR) begin
      if (ADDR == `A_CTRL) begin
        n.ctrl = WDATA[`F_CTRL];
        if (WDATA[`B_PORT] != st.ctrl[`B_PORT]) begin
          n.blank = 1'b1;
          n.clk_run = 1'b0;
          n.idle = '0;
          n.mode = rx_video_pkg::LM_CTRL;
          n.pre = '0;
        end
      end else if (ADDR == `A_VCFG) begin
        n.vcfg = WDATA[`F_VCFG];
      end else if (ADDR == `A_KEY) begin
        // Zero would lock the generator
        n.lfsr = (WDATA[`F_KEY] == '0) ? `LFSR_RST : WDATA[`F_KEY];
      end
    end
    n.pen = n.ctrl[`B_PORT] ? 2'h2 : 2'h1;
    n.ddc = n.ctrl[`B_DDC] ? 2'h2 : 2'h1;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st <= '0;
      st.blank <= 1'b1;
      st.pen <= `PEN_RST;
      st.ddc <= `PEN_RST;
      st.lfsr <= `LFSR_RST;
    end else begin
      st <= n;
    end
  end

  assign RDATA = st.rdata;
  assign PORT_EN = st.pen;
  assign DDC_EN = st.ddc;
  assign VID_OUT = st.vo;
  assign AUD_OUT = st.aud;
  assign AUX_OUT = st.aux;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  port_onehot_a: assert property ($onehot(PORT_EN) && PORT_EN[1] == st.ctrl[`B_PORT])
    else $error("port enable not one-hot");
  ddc_excl_a: assert property (WR && ADDR == `A_CTRL |=> DDC_EN[1] == $past(WDATA[`B_DDC]))
    else $error("data channel select wrong");
  key_hidden_a: assert property (RD && ADDR == `A_KEY |=> RDATA == '0)
    else $error("key readable");
  pwr_sync_a: assert property (RD && ADDR == `A_STAT |=> RDATA[1:0] == $past(PWR5V, 3))
    else $error("supply status wrong");
  clk_stop_a: assert property (st.idle == 8'(`CLK_STOP_CYC) && !vld |=> !st.clk_run)
    else $error("stopped clock missed");
  blank_hold_a: assert property ($rose(st.blank) |-> ##1 (!VID_OUT.de))
    else $error("output not blanked");
  xor_fresh_a: assert property (vld && st.ctrl[`B_DEC] && !WR |=> st.lfsr != $past(st.lfsr))
    else $error("mask not refreshed");
  aud_route_a: assert property (AUD_OUT.vld |-> !AUX_OUT.vld && $past(st.mode, 2) == rx_video_pkg::LM_ISL)
    else $error("audio misrouted");
  clamp_out_a: assert property (st.vcfg[`B_EMB] && !st.blank && VID_OUT.de && !st.vcfg[`B_MUX]
    && !st.vcfg[`B_DDR] |-> VID_OUT.d[11:4] != 8'h00 && VID_OUT.d[11:4] != 8'hff)
    else $error("sync code imitated");
  mux_clk_a: assert property (st.vcfg[`B_MUX] && !st.vcfg[`B_DIV] && !st.blank && st.ph == 2'h1
    ##1 st.ph == 2'h2 |=> VID_OUT.clk)
    else $error("mux clock wrong");

  island_c: cover property (st.mode == rx_video_pkg::LM_CTRL ##1 st.mode == rx_video_pkg::LM_ISL);
  sav_c: cover property (st.code && st.pde);
  deep_c: cover property (vld && st.vcfg[`F_DEEP] == `D_30 && !pix);
  aud_c: cover property (AUD_OUT.vld);
endmodule : rx_video_path
`default_nettype wire

// file: pkg/rx_video_defs.svh
// Register map, field positions, codes and timing constants of the receive video path
`ifndef RX_VIDEO_DEFS_SVH
`define RX_VIDEO_DEFS_SVH
// ----------------------------------------
// Register word indices
// ----------------------------------------
`define A_CTRL 4'h0
`define A_VCFG 4'h1
`define A_KEY 4'h2
`define A_STAT 4'h3
`define A_LINE 4'h4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define B_PORT 0
`define B_DDC 1
`define B_DEC 2
`define F_CTRL 2:0
`define B_UP 0
`define B_DN 1
`define B_RNG 2
`define B_EMB 3
`define B_MUX 4
`define B_DDR 5
`define B_DIV 6
`define F_WID 8:7
`define F_DEEP 10:9
`define F_VCFG 10:0
`define F_KEY 23:0
// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define W_24 2'h0
`define W_30 2'h1
`define W_36 2'h2
`define D_30 2'h1
`define D_36 2'h2
`define PEN_RST 2'h1
`define LFSR_RST 24'h000001
`define PRE_VID 4'h1
`define PRE_ISL 4'h5
`define PKT_AUD 8'h02
`define HDR_LEN 4'h8
`define TOK_00 10'h354
`define TOK_01 10'h0ab
`define TOK_10 10'h154
`define TOK_11 10'h2ab
`define TERC4_TAB {10'h2c3, 10'h163, 10'h271, 10'h28e, 10'h2c6, 10'h19c, 10'h139, 10'h2cc, \
  10'h13c, 10'h18e, 10'h11e, 10'h171, 10'h2e2, 10'h2e4, 10'h263, 10'h29c}
`define RNG_MUL 8'hdb
`define RNG_OFS 14'h0400
`define CLMP_LO 14'h0040
`define CLMP_HI 14'h3f80
`define VGA_W 12'h280
`define SAV_FF 12'hff0
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PER_NS 10
`define CLK_STOP_NS 1000
`define CLK_STOP_CYC (`CLK_STOP_NS / `CLK_PER_NS)
`define VID_STOP_NS 50000000
`endif

// file: pkg/rx_video_pkg.sv
// Types shared by the receive video path
`default_nettype none
package rx_video_pkg;
  typedef enum logic [1:0] {
    LM_CTRL = 2'b00,
    LM_VID = 2'b01,
    LM_ISL = 2'b10
  } lmode_t;

  typedef struct packed {
    logic [35:0] d;
    logic clk;
    logic hs;
    logic vs;
    logic de;
  } vout_t;

  typedef struct packed {
    logic [11:0] d;
    logic vld;
  } pkt_t;

  typedef struct packed {
    logic [2:0] ctrl;
    logic [10:0] vcfg;
    logic [23:0] lfsr;
    logic [31:0] rdata;
    logic [1:0] pw1;
    logic [1:0] pw2;
    lmode_t mode;
    logic [3:0] pre;
    logic [7:0] hdr;
    logic [3:0] hcnt;
    logic [7:0] idle;
    logic [22:0] vcnt;
    logic clk_run;
    logic vid_run;
    logic blank;
    logic [2:0] acc;
    logic [1:0] ph;
    logic divt;
    logic [13:0] cbh;
    logic [13:0] crh;
    logic ctog;
    logic de_q;
    logic pde;
    logic code;
    logic [7:0] xy;
    logic hs;
    logic vs;
    logic [11:0] pcnt;
    logic [11:0] line_len;
    logic ce_fmt;
    logic [35:0] w0;
    logic [35:0] w1;
    vout_t vo;
    pkt_t aud;
    pkt_t aux;
    logic [1:0] pen;
    logic [1:0] ddc;
  } st_t;
endpackage : rx_video_pkg
`default_nettype wire

// file: tb/rx_video_sink.sv
// Downstream video processor model: takes one word per rise of the output clock
`default_nettype none
module rx_video_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pixel bus from the receiver
  input wire rx_video_pkg::vout_t vin,
  // Last word taken and word count
  output logic [35:0] word,
  output int unsigned cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Capture
  // ----------------------------------------
  // Edge found in the system clock domain, so half-width modes are not seen here
  logic clk_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_q <= 1'b0;
      word <= '0;
      cnt <= 0;
    end else begin
      clk_q <= vin.clk;
      if (vin.clk && !clk_q && vin.de) begin
        word <= vin.d;
        cnt <= cnt + 1;
      end
    end
  end
endmodule : rx_video_sink
`default_nettype wire

// file: tb/rx_video_path_tb_top.sv
// Self-checking bench of the receive video path
`include "rx_video_defs.svh"
`default_nettype none
module rx_video_path_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [159:0] T4 = `TERC4_TAB;
  localparam logic [29:0] CTL0 = {`TOK_00, `TOK_00, `TOK_00};
  localparam logic [29:0] PRE_V = {`TOK_00, `TOK_01, `TOK_00};
  localparam logic [29:0] PRE_I = {`TOK_01, `TOK_01, `TOK_00};
  logic clk, sys_rst, wr, rd, saw_code, emb, rng;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [29:0] sym0, sym1;
  logic [1:0] vld, pwr, port_en, ddc_en;
  rx_video_pkg::vout_t vout;
  rx_video_pkg::pkt_t aud, aux;
  logic [35:0] sink_word;
  int unsigned sink_cnt;
  int err_count, cmp_count;
  logic [11:0] exp_aud[$];
  logic [11:0] exp_aux[$];

  rx_video_path #(.VID_STOP_CYC(200)) u_dut (
    .CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SYM_P0(sym0), .SYM_P1(sym1), .SYM_VLD(vld), .PWR5V(pwr),
    .PORT_EN(port_en), .DDC_EN(ddc_en), .VID_OUT(vout), .AUD_OUT(aud), .AUX_OUT(aux)
  );
  rx_video_sink u_sink (
    .clk(clk), .rst(sys_rst), .vin(vout), .word(sink_word), .cnt(sink_cnt)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // Tasks and model
  // ----------------------------------------
  task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : reg_wr

  task automatic rd_chk(string w, logic [3:0] a, logic [31:0] m, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(w, 40'(rdata & m), 40'(e));
  endtask : rd_chk

  // Stale port 0 symbols are inverted so a late sample never matches by luck
  task automatic send(logic [29:0] s, logic [1:0] m, int gap);
    @(posedge clk);
    sym0 <= s;
    sym1 <= ~s;
    vld <= m;
    @(posedge clk);
    vld <= 2'b00;
    sym0 <= ~s;
    repeat (gap) @(posedge clk);
  endtask : send

  function automatic logic [9:0] enc8(logic [7:0] q);
    logic [7:0] d;
    d[0] = q[0];
    for (int i = 1; i < 8; i++) begin
      d[i] = d[i-1] ^ q[i];
    end
    return {2'b01, d};
  endfunction : enc8

  // Byte fc would encode to a control token
  function automatic logic [7:0] rnd8();
    logic [7:0] v;
    v = 8'($urandom());
    return (v == 8'hfc) ? 8'hfd : v;
  endfunction : rnd8

  function automatic logic [11:0] exp8(logic [7:0] x);
    logic [7:0] v;
    v = rng ? 8'(16 + (int'(x) * 219) / 256) : x;
    if (emb && v < 8'h01) return 12'h010;
    if (emb && v > 8'hfe) return 12'hfe0;
    return {v, 4'h0};
  endfunction : exp8

  task automatic pix(logic [7:0] r, logic [7:0] g, logic [7:0] b);
    int unsigned n0;
    n0 = sink_cnt;
    send({enc8(r), enc8(g), enc8(b)}, 2'b11, 6);
    for (int i = 0; i < 20 && sink_cnt == n0; i++) @(posedge clk);
    #1 check("pixel", 40'(sink_word), 40'({exp8(r), exp8(g), exp8(b)}));
  endtask : pix

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    if (!sys_rst && aud.vld) begin
      check("audio due", 40'(exp_aud.size() > 0), 40'd1);
      if (exp_aud.size() > 0) check("audio", 40'(aud.d), 40'(exp_aud.pop_front()));
    end
    if (!sys_rst && aux.vld) begin
      check("aux due", 40'(exp_aux.size() > 0), 40'd1);
      if (exp_aux.size() > 0) check("aux", 40'(aux.d), 40'(exp_aux.pop_front()));
    end
    if (vout.d[23:12] === 12'hff0 && vout.de === 1'b0) saw_code <= 1'b1;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [7:0] hb;
    logic [3:0] n0, n1, n2;
    int unsigned nw;
    logic [35:0] dw[2];
    sys_rst = 1'b1;
    {wr, rd, addr, wdata, vld, sym0, sym1, pwr} = '0;
    {err_count, cmp_count, saw_code, emb, rng} = '0;
    void'($urandom(36));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    #1 check("port_en", 40'(port_en), 40'h1);
    check("ddc_en", 40'(ddc_en), 40'h1);
    check("vid_out", 40'(vout), 40'h0);
    rd_chk("vcfg", `A_VCFG, 32'h7ff, 32'h0);
    reg_wr(`A_KEY, $urandom());
    rd_chk("key", `A_KEY, 32'hffffffff, 32'h0);
    rd_chk("unmapped", 4'hf, 32'hffffffff, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pwr <= 2'($urandom());
      repeat (4) @(posedge clk);
      rd_chk("supply", `A_STAT, 32'h3, 32'(pwr));
    end
    for (int c = 0; c < 4; c++) begin
      reg_wr(`A_CTRL, 32'(c));
      #1 check("port_en", 40'(port_en), 40'(2'b01 << c[0]));
      check("ddc_en", 40'(ddc_en), 40'(2'b01 << c[1]));
      check("blank", 40'(vout), 40'h0);
    end
    $display("test registers done");
    send(CTL0, 2'b01, 2);
    rd_chk("idle port", `A_STAT, 32'h4, 32'h0);
    send(CTL0, 2'b10, 2);
    rd_chk("clk run", `A_STAT, 32'h4, 32'h4);
    repeat (85) @(posedge clk);
    rd_chk("clk held", `A_STAT, 32'h4, 32'h4);
    repeat (15) @(posedge clk);
    rd_chk("clk stop", `A_STAT, 32'h4, 32'h0);
    $display("test link clock done");
    reg_wr(`A_CTRL, 32'h0);
    send(PRE_V, 2'b11, 1);
    send({3{enc8(8'h5a)}}, 2'b11, 6);
    for (int i = 0; i < 4; i++) begin
      pix(rnd8(), rnd8(), rnd8());
    end
    rd_chk("video run", `A_STAT, 32'h8, 32'h8);
    $display("test video done");
    send(CTL0, 2'b11, 1);
    reg_wr(`A_VCFG, 32'h8);
    emb = 1'b1;
    saw_code = 1'b0;
    send(PRE_V, 2'b11, 1);
    send({3{enc8(8'h00)}}, 2'b11, 6);
    send({3{enc8(8'h00)}}, 2'b11, 6);
    pix(8'h00, 8'h00, 8'h00);
    pix(8'hff, 8'hff, 8'hff);
    check("start code", 40'(saw_code), 40'h1);
    $display("test embedded done");
    send(CTL0, 2'b11, 1);
    reg_wr(`A_VCFG, 32'h4);
    rng = 1'b1;
    emb = 1'b0;
    send(PRE_V, 2'b11, 1);
    send({3{enc8(8'h5a)}}, 2'b11, 6);
    pix(rnd8(), rnd8(), rnd8());
    pix(8'hff, 8'h00, 8'h80);
    rng = 1'b0;
    // Multiplexed bus: luma word first, then the chroma word of the same pixel
    reg_wr(`A_VCFG, 32'h10);
    nw = sink_cnt;
    send({enc8(8'h33), enc8(8'h22), enc8(8'h11)}, 2'b11, 0);
    for (int i = 0; i < 20 && sink_cnt != nw + 1; i++) @(posedge clk);
    #1 check("luma word", 40'(sink_word), 40'h220);
    for (int i = 0; i < 20 && sink_cnt != nw + 2; i++) @(posedge clk);
    #1 check("chroma word", 40'(sink_word), 40'h110);
    $display("test range and mux done");
    reg_wr(`A_VCFG, 32'h0);
    // Same seed and symbol order must give the same masked pixel
    for (int k = 0; k < 2; k++) begin
      send(CTL0, 2'b11, 1);
      reg_wr(`A_KEY, 32'h00a5c3);
      reg_wr(`A_CTRL, 32'h4);
      send(PRE_V, 2'b11, 1);
      send({3{enc8(8'h5a)}}, 2'b11, 6);
      nw = sink_cnt;
      send({3{enc8(8'h3c)}}, 2'b11, 6);
      for (int i = 0; i < 20 && sink_cnt == nw; i++) @(posedge clk);
      dw[k] = sink_word;
    end
    check("masked", 40'(dw[0] != {3{12'h3c0}}), 40'h1);
    check("reseed", 40'(dw[1]), 40'(dw[0]));
    reg_wr(`A_CTRL, 32'h0);
    $display("test decrypt done");
    send(CTL0, 2'b11, 1);
    reg_wr(`A_VCFG, 32'h0);
    for (int k = 0; k < 2; k++) begin
      hb = (k == 0) ? `PKT_AUD : 8'h05;
      send(CTL0, 2'b11, 1);
      send(PRE_I, 2'b11, 1);
      send({3{T4[9:0]}}, 2'b11, 1);
      for (int i = 0; i < 10; i++) begin
        n0 = 4'($urandom());
        n1 = 4'($urandom());
        n2 = 4'($urandom());
        if (i < 8) n0[2] = hb[i];
        if (i < 8 || k == 1) exp_aux.push_back({n2, n1, n0});
        else exp_aud.push_back({n2, n1, n0});
        send({T4[n2*10 +: 10], T4[n1*10 +: 10], T4[n0*10 +: 10]}, 2'b11, 1);
      end
      repeat (4) @(posedge clk);
      check("audio left", 40'(exp_aud.size()), 40'h0);
      check("aux left", 40'(exp_aux.size()), 40'h0);
    end
    $display("test islands done");
    repeat (220) @(posedge clk);
    rd_chk("video stop", `A_STAT, 32'h8, 32'h0);
    $display("test video stop done");
    stop_test();
  end

  initial begin
    #50us;
    err_count++;
    $display("[FAIL] watchdog expected end seen hang");
    stop_test();
  end
endmodule : rx_video_path_tb_top
`default_nettype wire
